//--- src/fuhi_map.vh
/*
 * Constants for the floating-point unit host interface: instruction field
 * positions, opcode codes and reset values.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef FUHI_MAP_VH
`define FUHI_MAP_VH

// ---------------------------------------------------------------------
// Instruction fields used to recognise arithmetic float operations
// ---------------------------------------------------------------------
`define FUHI_OP_HI       31
`define FUHI_OP_LO       30
`define FUHI_OP3_HI      24
`define FUHI_OP3_LO      19
`define FUHI_OP_ARITH    2'h2
`define FUHI_OP3_FPOP1   6'h34
`define FUHI_OP3_FPOP2   6'h35

// ---------------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------------
`define FUHI_DATA_W      32
`define FUHI_ADDR_W      30
`define FUHI_ADDR_LSB    2
`define FUHI_QUEUE_DEPTH 4
`define FUHI_RST_WORD    32'h0000_0000
`define FUHI_RST_ADDR    30'h0000_0000
`define FUHI_RST_CC      2'h0
`define FUHI_RST_HOLD    1'b0
`define FUHI_RST_CCV     1'b1
`define FUHI_RST_PRESENT 1'b0

`endif

//--- src/fuhi_fetch_pair.v
/*
 * Fetch snooper: keeps the last two instruction words and word addresses
 * seen on the shared bus, and presents one of them on request.
 * Assumes fetch strobes are synchronous to clk_i.
 */
`timescale 1ns/100ps
`include "fuhi_map.vh"

module fuhi_fetch_pair
#(
   parameter DATA_W = `FUHI_DATA_W,
   parameter ADDR_W = `FUHI_ADDR_W
)
(
   input  wire              clk_i,
   input  wire              reset_i,
   input  wire              capture_i,
   input  wire [DATA_W-1:0] word_i,
   input  wire [ADDR_W-1:0] addr_i,
   input  wire              pick_older_i,
   output reg  [DATA_W-1:0] sel_word_o,
   output reg  [ADDR_W-1:0] sel_addr_o
);

   reg [DATA_W-1:0] last_word;
   reg [ADDR_W-1:0] last_addr;
   reg [DATA_W-1:0] prev_word;
   reg [ADDR_W-1:0] prev_addr;

   // ------------------------------------------------------------------
   // Two-deep history, shifted on every captured fetch
   // ------------------------------------------------------------------
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         last_word <= `FUHI_RST_WORD;
         last_addr <= `FUHI_RST_ADDR;
         prev_word <= `FUHI_RST_WORD;
         prev_addr <= `FUHI_RST_ADDR;
      end
      else if (capture_i)
      begin
         prev_word <= last_word;
         prev_addr <= last_addr;
         last_word <= word_i;
         last_addr <= addr_i;
      end
   end

   // Combinational pick, so the issue stage sees the word of this decode
   always @*
   begin
      if (pick_older_i)
      begin
         sel_word_o = prev_word;
         sel_addr_o = prev_addr;
      end
      else
      begin
         sel_word_o = last_word;
         sel_addr_o = last_addr;
      end
   end

endmodule

//--- src/fuhi_exc_req.v
/*
 * Exception request latch with a one-cycle delayed copy used to drop the
 * hold after the request has been visible for a full cycle.
 * Assumes event and acknowledge are synchronous to clk_i.
 */
`timescale 1ns/100ps

module fuhi_exc_req
(
   input  wire clk_i,
   input  wire reset_i,
   input  wire event_i,
   input  wire ack_i,
   output reg  req_o,
   output reg  req_aged_o
);

   // ------------------------------------------------------------------
   // Request stays up until acknowledged; a new event beats the ack
   // ------------------------------------------------------------------
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         req_o      <= 1'b0;
         req_aged_o <= 1'b0;
      end
      else
      begin
         req_o      <= event_i | (req_o & ~ack_i);
         req_aged_o <= req_o & (event_i | ~ack_i);
      end
   end

endmodule

//--- src/fuhi_top.v
/*
 * Host-facing signalling of a floating-point coprocessor: fetch snooping,
 * instruction issue, pipeline holds and freezes, exception handshake,
 * flush, data bus drive control and presence indication.
 * Assumes all pins are synchronous to clk_i; the arithmetic core sits on
 * the core-side ports and reports dependencies, exceptions and codes.
 */
// What this block does
// [RULE1] Capture the word address bits 31..2 on each instruction fetch.
// [RULE2] Copy the data bus word while the opcode fetch cycle input is high.
// [RULE3] First issue select starts the most recently fetched word.
// [RULE4] Second issue select starts the word fetched before the latest.
// [RULE5] Flush aborts unqueued instructions; queued ones still complete.
// [RULE6] Integer unit flushes on traps and reissues aborted instructions later.
// [RULE7] Raise exception request on a float exception until acknowledged.
// [RULE8] Trap acknowledge drops the exception request.
// [RULE9] Assert hold on resource or data dependency; release when cleared.
// [RULE10] Condition valid output high when codes valid; low freezes pipeline.
// [RULE11] Condition code outputs mirror the status register code field.
// [RULE12] Freeze notice high whenever hold is high or condition valid low.
// [RULE13] Stay frozen while coprocessor condition valid is low.
// [RULE14] Stay frozen while coprocessor hold is high.
// [RULE15] Bus drive enable low turns data bus drivers off at once; data_oe_o here drops at the next rising edge.
// [RULE16] System drops bus drive enable when another master needs the bus.
// [RULE17] Instructions, load data and store data all use the 32-bit bus.
// [RULE18] Drive the unit-present output low continuously.
// [RULE19] Frozen work resumes only with all holds off and both valids on.
// [RULE20] Freeze notice changes on rising edge; hold and valid on falling.
// [RULE21] When excepting while holding, release hold a cycle after request.
// [RULE22] Test tristate input high switches every output driver off.
// [RULE23] Reset clears request, hold, issue state; valid high; bus undriven.
`timescale 1ns/100ps
`include "fuhi_map.vh"

module fuhi_top
#(
   parameter DATA_W      = `FUHI_DATA_W,
   parameter ADDR_W      = `FUHI_ADDR_W,
   parameter QUEUE_DEPTH = `FUHI_QUEUE_DEPTH
)
(
   input  wire              clk_i,
   input  wire              reset_i,
   // Integer unit and coprocessor
   input  wire              opcode_fetch_cycle_i,
   input  wire              issue_last_fetched_i,
   input  wire              issue_second_last_fetched_i,
   input  wire              flush_i,
   input  wire              trap_taken_ack_i,
   input  wire              coproc_cond_valid_i,
   input  wire              coproc_hold_in_i,
   output reg               float_cond_valid_o,
   output reg  [1:0]        float_cond_code_o,
   output reg               float_exception_req_o,
   output reg               float_hold_out_o,
   output reg               float_unit_present_n_o,
   // System and memory
   input  wire [31:2]       addr_i,
   input  wire [DATA_W-1:0] data_i,
   output reg  [DATA_W-1:0] data_o,
   output reg               data_oe_o,
   input  wire              mem_stall_a_i,
   input  wire              mem_stall_b_i,
   input  wire              bus_stall_i,
   input  wire              mem_strobe_i,
   input  wire              bus_drive_enable_i,
   input  wire              test_tristate_all_i,
   output reg               pipe_freeze_notice_o,
   output reg               outputs_enable_o,
   // Arithmetic core side
   input  wire              core_dep_stall_i,
   input  wire              core_exception_i,
   input  wire              core_queue_done_i,
   input  wire              core_cc_pending_i,
   input  wire [1:0]        float_status_reg_cc_i,
   input  wire              core_load_take_i,
   input  wire              core_store_req_i,
   input  wire [DATA_W-1:0] core_store_data_i,
   output reg               issue_valid_o,
   output reg  [DATA_W-1:0] issue_word_o,
   output reg  [ADDR_W-1:0] issue_addr_o,
   output reg               issue_is_fpop_o,
   output reg               flush_o,
   output reg               load_valid_o,
   output reg  [DATA_W-1:0] load_data_o
);

   localparam CNT_W = 8;

   // ------------------------------------------------------------------
   // Issue state machine, one-hot
   // ------------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_WAIT  = 3'h2;
   localparam [2:0] ST_ABORT = 3'h4;

   reg  [2:0]        state;
   reg  [2:0]        next_state;
   reg  [DATA_W-1:0] pend_word;
   reg  [ADDR_W-1:0] pend_addr;
   reg               pend_fpop;
   reg  [CNT_W-1:0]  queue_count;
   reg  [CNT_W-1:0]  next_queue_count;
   reg               next_issue_valid;
   wire [DATA_W-1:0] sel_word;
   wire [ADDR_W-1:0] sel_addr;
   wire              exc_req;
   wire              exc_aged;
   wire              issue_req;
   wire              sel_fpop;
   wire              queue_full;
   wire              frozen;
   wire              fetch_take;
   wire              resource_hold;
   wire              next_hold;
   wire              next_ccv;

   // ------------------------------------------------------------------
   // Fetch snooping
   // ------------------------------------------------------------------
   // During a cache miss the word only counts when the memory strobe marks it
   assign fetch_take = opcode_fetch_cycle_i &                          // RULE2
                       (~(mem_stall_a_i | mem_stall_b_i | bus_stall_i) | mem_strobe_i);

   fuhi_fetch_pair
   #(
      .DATA_W (DATA_W),
      .ADDR_W (ADDR_W)
   )
   u_fetch
   (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .capture_i    (fetch_take),
      .word_i       (data_i),                                          // RULE17
      .addr_i       (addr_i[31:`FUHI_ADDR_LSB]),                       // RULE1
      .pick_older_i (issue_second_last_fetched_i),                     // RULE4
      .sel_word_o   (sel_word),
      .sel_addr_o   (sel_addr)
   );

   assign issue_req = issue_last_fetched_i | issue_second_last_fetched_i; // RULE3

   assign sel_fpop = (sel_word[`FUHI_OP_HI:`FUHI_OP_LO] == `FUHI_OP_ARITH) &&
                     ((sel_word[`FUHI_OP3_HI:`FUHI_OP3_LO] == `FUHI_OP3_FPOP1) ||
                      (sel_word[`FUHI_OP3_HI:`FUHI_OP3_LO] == `FUHI_OP3_FPOP2));

   assign queue_full = (queue_count >= QUEUE_DEPTH[CNT_W-1:0]);

   // ------------------------------------------------------------------
   // Exception handshake
   // ------------------------------------------------------------------
   fuhi_exc_req u_exc
   (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .event_i    (core_exception_i),                                  // RULE7
      .ack_i      (trap_taken_ack_i),                                  // RULE8
      .req_o      (exc_req),
      .req_aged_o (exc_aged)
   );

   // ------------------------------------------------------------------
   // Freeze condition seen by the front end and load path
   // ------------------------------------------------------------------
   assign frozen = mem_stall_a_i | mem_stall_b_i | bus_stall_i |       // RULE19
                   coproc_hold_in_i |                                  // RULE14
                   ~coproc_cond_valid_i |                              // RULE13
                   float_hold_out_o | ~float_cond_valid_o;

   // Queue-full stall only matters for an incoming arithmetic operation
   assign resource_hold = issue_req & sel_fpop & queue_full;

   // Holding through an exception would deadlock the trap, so it drops
   // once the request has stood a full cycle
   assign next_hold = (core_dep_stall_i | resource_hold) & ~exc_aged;  // RULE9 RULE21

   // An aborted compare leaves the old codes, so validity returns at once
   assign next_ccv = ~(core_cc_pending_i & ~flush_i);                  // RULE10

   // ------------------------------------------------------------------
   // Hold and condition valid change on the falling edge
   // ------------------------------------------------------------------
   always @(negedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         float_hold_out_o   <= `FUHI_RST_HOLD;                         // RULE23
         float_cond_valid_o <= `FUHI_RST_CCV;
      end
      else
      begin
         float_hold_out_o   <= next_hold;                              // RULE20
         float_cond_valid_o <= next_ccv;
      end
   end

   // ------------------------------------------------------------------
   // Issue control
   // ------------------------------------------------------------------
   always @*
   begin
      next_state       = state;
      next_issue_valid = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (flush_i)
               next_state = ST_IDLE;
            else if (issue_req && (frozen || resource_hold))
               next_state = ST_WAIT;
            else if (issue_req)
               next_issue_valid = 1'b1;
         end
         ST_WAIT:
         begin
            if (flush_i)
               next_state = ST_ABORT;                                  // RULE5
            else if (!frozen && !(pend_fpop && queue_full))
            begin
               next_issue_valid = 1'b1;
               next_state       = ST_IDLE;
            end
         end
         ST_ABORT:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always @*
   begin
      next_queue_count = queue_count;
      if (next_issue_valid && (state == ST_IDLE ? sel_fpop : pend_fpop))
         next_queue_count = next_queue_count + 8'h01;
      if (core_queue_done_i && (queue_count != 8'h00))
         next_queue_count = next_queue_count - 8'h01;
   end

   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state           <= ST_IDLE;                                   // RULE23
         pend_word       <= `FUHI_RST_WORD;
         pend_addr       <= `FUHI_RST_ADDR;
         pend_fpop       <= 1'b0;
         queue_count     <= 8'h00;
         issue_valid_o   <= 1'b0;
         issue_word_o    <= `FUHI_RST_WORD;
         issue_addr_o    <= `FUHI_RST_ADDR;
         issue_is_fpop_o <= 1'b0;
         flush_o         <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         queue_count   <= next_queue_count;
         issue_valid_o <= next_issue_valid;
         // Queued work is untouched; only the core's front end sees the flush
         flush_o       <= flush_i;                                     // RULE5
         if (state == ST_IDLE && issue_req)
         begin
            pend_word <= sel_word;                                     // RULE3 RULE4
            pend_addr <= sel_addr;
            pend_fpop <= sel_fpop;
         end
         if (next_issue_valid)
         begin
            issue_word_o    <= (state == ST_IDLE) ? sel_word : pend_word;
            issue_addr_o    <= (state == ST_IDLE) ? sel_addr : pend_addr;
            issue_is_fpop_o <= (state == ST_IDLE) ? sel_fpop : pend_fpop;
         end
      end
   end

   // ------------------------------------------------------------------
   // Rising-edge outputs: freeze notice, codes, request, loads and bus
   // ------------------------------------------------------------------
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pipe_freeze_notice_o   <= 1'b0;
         float_cond_code_o      <= `FUHI_RST_CC;
         float_exception_req_o  <= 1'b0;
         float_unit_present_n_o <= `FUHI_RST_PRESENT;
         outputs_enable_o       <= 1'b0;
         load_valid_o           <= 1'b0;
         load_data_o            <= `FUHI_RST_WORD;
         data_o                 <= `FUHI_RST_WORD;
         data_oe_o              <= 1'b0;                               // RULE23
      end
      else
      begin
         pipe_freeze_notice_o   <= float_hold_out_o | ~float_cond_valid_o; // RULE12 RULE20
         float_cond_code_o      <= float_status_reg_cc_i;              // RULE11
         float_exception_req_o  <= exc_req;                            // RULE7 RULE8
         float_unit_present_n_o <= `FUHI_RST_PRESENT;                  // RULE18
         outputs_enable_o       <= ~test_tristate_all_i;               // RULE22
         load_valid_o           <= core_load_take_i & ~frozen;         // RULE19
         if (core_load_take_i && !frozen)
            load_data_o <= data_i;                                     // RULE17
         data_o    <= core_store_data_i;
         // Drivers drop regardless of the store in progress
         data_oe_o <= core_store_req_i & bus_drive_enable_i &          // RULE15
                      ~test_tristate_all_i;                            // RULE22
      end
   end

endmodule

//--- verif/fuhi_props.sv
/* Concurrent checks on the ports of fuhi_top, bound into it.
   Assumes one clock; hold and condition valid move on the falling edge. */
`timescale 1ns/100ps
module fuhi_props
(
   input wire        clk_i,
   input wire        reset_i,
   input wire        flush_i,
   input wire        trap_taken_ack_i,
   input wire        coproc_cond_valid_i,
   input wire        coproc_hold_in_i,
   input wire        float_cond_valid_o,
   input wire [1:0]  float_cond_code_o,
   input wire        float_exception_req_o,
   input wire        float_hold_out_o,
   input wire        float_unit_present_n_o,
   input wire [31:0] data_o,
   input wire        data_oe_o,
   input wire        mem_stall_a_i,
   input wire        mem_stall_b_i,
   input wire        bus_stall_i,
   input wire        bus_drive_enable_i,
   input wire        test_tristate_all_i,
   input wire        pipe_freeze_notice_o,
   input wire        core_dep_stall_i,
   input wire        core_exception_i,
   input wire        core_cc_pending_i,
   input wire [1:0]  float_status_reg_cc_i,
   input wire        core_store_req_i,
   input wire [31:0] core_store_data_i,
   input wire        issue_valid_o,
   input wire        flush_o,
   input wire        load_valid_o
);
   // ---------------------------------------------------------------
   // Freeze sources and exception sequence
   // ---------------------------------------------------------------
   wire frozen_in = mem_stall_a_i | mem_stall_b_i | bus_stall_i | coproc_hold_in_i |
                    ~coproc_cond_valid_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_exc_pend;
      float_exception_req_o ##1 float_exception_req_o;
   endsequence

   a_present_low: assert property (float_unit_present_n_o == 1'b0)
      else $error("present output not low");
   a_freeze_quiet: assert property (frozen_in |=> !issue_valid_o && !load_valid_o)
      else $error("issue or load while frozen");
   a_flush_abort: assert property (flush_i |=> !issue_valid_o && flush_o)
      else $error("issue survived flush");
   a_exc_raise: assert property (core_exception_i |-> ##2 float_exception_req_o)
      else $error("exception request not raised");
   a_exc_stands: assert property (float_exception_req_o && !trap_taken_ack_i &&
      !$past(trap_taken_ack_i) |=> float_exception_req_o)
      else $error("exception request dropped without ack");
   a_exc_drop: assert property (float_exception_req_o && trap_taken_ack_i && !core_exception_i
      |-> ##2 !float_exception_req_o)
      else $error("exception request stayed after ack");
   a_hold_exc: assert property (s_exc_pend |-> !float_hold_out_o)
      else $error("hold kept during exception");
   a_hold_dep: assert property (@(negedge clk_i)
      core_dep_stall_i && !float_exception_req_o |=> float_hold_out_o)
      else $error("hold missing on dependency");
   a_ccv_pending: assert property (@(negedge clk_i)
      ##1 float_cond_valid_o == !$past(core_cc_pending_i && !flush_i))
      else $error("condition valid wrong");
   a_notice_follow: assert property (##1 pipe_freeze_notice_o ==
      $past(float_hold_out_o || !float_cond_valid_o))
      else $error("freeze notice wrong");
   a_cc_mirror: assert property ($stable(float_status_reg_cc_i) && !$past(reset_i)
      |-> float_cond_code_o == float_status_reg_cc_i)
      else $error("condition code mismatch");
   a_bus_off: assert property (!bus_drive_enable_i || test_tristate_all_i |=> !data_oe_o)
      else $error("bus driven while disabled");
   a_bus_store: assert property (core_store_req_i && bus_drive_enable_i && !test_tristate_all_i
      |=> data_oe_o && data_o == $past(core_store_data_i))
      else $error("store data not driven");
endmodule

bind fuhi_top fuhi_props i_props (.*);

//--- verif/fuhi_iu_model.sv
/* Integer unit model: takes the requested float trap and acknowledges it.
   Assumes it shares clock and reset with the design. */
`timescale 1ns/100ps
module fuhi_iu_model
(
   input  wire       clk_i,
   input  wire       reset_i,
   input  wire [3:0] ack_delay_i,
   input  wire       exc_req_i,
   output reg        ack_o
);
   reg [3:0] wait_cnt;

   // Ack holds until the request is seen low, so no drop is missed
   always @(posedge clk_i)
   begin
      if (reset_i || !exc_req_i)
      begin
         wait_cnt <= 4'h0;
         ack_o    <= 1'b0;
      end
      else if (wait_cnt == ack_delay_i)
         ack_o <= 1'b1;
      else
         wait_cnt <= wait_cnt + 4'h1;
   end
endmodule

//--- verif/float_unit_host_interface_tb.sv
/* Directed bench for fuhi_top; fuhi_iu_model answers exception traps.
   Assumes inputs change 1 ns after each rising clock edge. */
`timescale 1ns/100ps
module float_unit_host_interface_tb;
   logic        clk_i, reset_i, opcode_fetch_cycle_i, issue_last_fetched_i, flush_i;
   logic        issue_second_last_fetched_i, trap_taken_ack_i, coproc_cond_valid_i;
   logic        coproc_hold_in_i, mem_stall_a_i, mem_stall_b_i, bus_stall_i, mem_strobe_i;
   logic        bus_drive_enable_i, test_tristate_all_i, core_dep_stall_i, core_exception_i;
   logic        core_queue_done_i, core_cc_pending_i, core_load_take_i, core_store_req_i;
   logic        float_cond_valid_o, float_exception_req_o, float_hold_out_o, data_oe_o;
   logic        float_unit_present_n_o, pipe_freeze_notice_o, outputs_enable_o, flush_o;
   logic        issue_valid_o, issue_is_fpop_o, load_valid_o;
   logic [1:0]  float_status_reg_cc_i, float_cond_code_o;
   logic [31:2] addr_i;
   logic [29:0] issue_addr_o;
   logic [31:0] data_i, core_store_data_i, data_o, issue_word_o, load_data_o;
   logic [3:0]  ack_delay;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   localparam logic [31:0] W_FPOP = 32'h81a0_0843;
   localparam logic [31:0] W_INT  = 32'h0123_4567;

   fuhi_top i_dut (.*);
   fuhi_iu_model i_iu (.clk_i(clk_i), .reset_i(reset_i), .ack_delay_i(ack_delay),
      .exc_req_i(float_exception_req_o), .ack_o(trap_taken_ack_i));

   // ---------------------------------------------------------------
   // Shared helpers
   // ---------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // Bounded wait: 0 issue, 1 request up, 2 request down
   task wait_for(input int s, input int n, output logic hit);
      hit = 1'b0;
      repeat (n)
      begin
         if (((s == 0) ? issue_valid_o : float_exception_req_o ^ (s > 1)) === 1'b1) hit = 1'b1;
         if (!hit) tick(1);
      end
   endtask
   task fetch(input logic [31:0] w, input logic [31:2] a);
      opcode_fetch_cycle_i = 1'b1;
      data_i = w;
      addr_i = a;
      tick(1);
      opcode_fetch_cycle_i = 1'b0;
      data_i = ~w;
      tick(1);
   endtask
   task issue(input logic older);
      issue_second_last_fetched_i = older;
      issue_last_fetched_i = !older;
      tick(1);
      {issue_second_last_fetched_i, issue_last_fetched_i} = 2'h0;
   endtask
   task set_freeze(input int k, input logic on);
      case (k)
         0: mem_stall_a_i = on;
         1: mem_stall_b_i = on;
         2: bus_stall_i = on;
         3: coproc_hold_in_i = on;
         default: coproc_cond_valid_i = !on;
      endcase
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_reset;
      chk1(float_hold_out_o, 1'b0);
      chk1(float_cond_valid_o, 1'b1);
      chk1(float_exception_req_o | data_oe_o, 1'b0);
      chk1(float_unit_present_n_o, 1'b0);
   endtask
   task t_fetch_issue;
      logic hit;
      fetch(W_FPOP, 30'h0040_0010);
      fetch(W_INT, 30'h0040_0011);
      issue(1'b1);
      wait_for(0, 4, hit);
      chk1(hit, 1'b1);
      chk(issue_word_o, W_FPOP);
      chk({2'h0, issue_addr_o}, 32'h0040_0010);
      chk1(issue_is_fpop_o, 1'b1);
      tick(1);
      issue(1'b0);
      wait_for(0, 4, hit);
      chk(issue_word_o, W_INT);
      chk1(issue_is_fpop_o, 1'b0);
   endtask
   task t_freeze;
      logic hit;
      for (int k = 0; k < 5; k++)
      begin
         set_freeze(k, 1'b1);
         issue(1'b0);
         wait_for(0, 4, hit);
         chk1(hit, 1'b0);
         set_freeze(k, 1'b0);
         wait_for(0, 4, hit);
         chk1(hit, 1'b1);
      end
   endtask
   task t_flush;
      logic hit;
      coproc_hold_in_i = 1'b1;
      issue(1'b0);
      flush_i = 1'b1;
      tick(1);
      flush_i = 1'b0;
      chk1(flush_o, 1'b1);
      coproc_hold_in_i = 1'b0;
      wait_for(0, 4, hit);
      chk1(hit, 1'b0);
   endtask
   task t_exception(input logic [3:0] d);
      logic hit;
      ack_delay = d;
      core_dep_stall_i = 1'b1;
      tick(2);
      chk1(float_hold_out_o, 1'b1);
      chk1(pipe_freeze_notice_o, 1'b1);
      core_exception_i = 1'b1;
      tick(1);
      core_exception_i = 1'b0;
      wait_for(1, 3, hit);
      chk1(hit, 1'b1);
      tick(1);
      chk1(float_hold_out_o, 1'b0);
      core_dep_stall_i = 1'b0;
      wait_for(2, 12, hit);
      chk1(hit, 1'b1);
   endtask
   task t_codes;
      core_cc_pending_i = 1'b1;
      tick(2);
      chk1(float_cond_valid_o, 1'b0);
      chk1(pipe_freeze_notice_o, 1'b1);
      core_cc_pending_i = 1'b0;
      tick(2);
      chk({30'h0, float_cond_valid_o, pipe_freeze_notice_o}, 32'h2);
      for (int v = 0; v < 4; v++)
      begin
         float_status_reg_cc_i = v[1:0];
         tick(2);
         chk({30'h0, float_cond_code_o}, v);
      end
   endtask
   task t_bus;
      core_store_req_i = 1'b1;
      core_store_data_i = 32'h5a5a_0ff0;
      tick(1);
      chk({data_oe_o, data_o[30:0]}, 32'hda5a_0ff0);
      bus_drive_enable_i = 1'b0;
      tick(1);
      chk1(data_oe_o, 1'b0);
      bus_drive_enable_i = 1'b1;
      test_tristate_all_i = 1'b1;
      tick(1);
      chk1(data_oe_o | outputs_enable_o, 1'b0);
      {test_tristate_all_i, core_store_req_i} = 2'h0;
      data_i = 32'h3c3c_a5a5;
      core_load_take_i = 1'b1;
      tick(1);
      core_load_take_i = 1'b0;
      data_i = 32'hc3c3_5a5a;
      chk1(outputs_enable_o & load_valid_o, 1'b1);
      chk(load_data_o, 32'h3c3c_a5a5);
   endtask

   task conclude;
      $display("Mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Run needs about 100 cycles
   initial
   begin
      #20000;
      n_mismatch++;
      conclude();
   end
   initial
   begin
      {opcode_fetch_cycle_i, issue_last_fetched_i, issue_second_last_fetched_i, flush_i,
       coproc_hold_in_i, mem_stall_a_i, mem_stall_b_i, bus_stall_i, mem_strobe_i,
       test_tristate_all_i, core_dep_stall_i, core_exception_i, core_queue_done_i,
       core_cc_pending_i, core_load_take_i, core_store_req_i} = 16'h0;
      {float_status_reg_cc_i, addr_i, data_i, core_store_data_i} = 96'h0;
      {coproc_cond_valid_i, bus_drive_enable_i, reset_i} = 3'h7;
      ack_delay = 4'h0;
      tick(11);
      t_reset();
      tick(1);
      reset_i = 1'b0;
      tick(2);
      t_fetch_issue();
      t_freeze();
      t_flush();
      t_exception(4'h0);
      t_exception(4'h4);
      t_codes();
      t_bus();
      conclude();
   end
endmodule
